// *** hdl/hsc_ctrl.sv ***
// control, serial port and pin logic of the dual high side switch
// Summary of operation
// - fixed 16-bit words, daisy chain capable
// - words shifted msb first, 15 to 0
// - traffic only with select low; latch on rise
// - select fall loads readout, enables output
// - sample on sclk fall, drive on rise
// - select high: ignore sclk/si, output off
// - reset pin low holds registers at reset
// - reset low: sleep after inputs low delay
// - sleep delay nominally 250 ms
// - reset pin rise wakes, starts watchdog
// - toggle bit must alternate within timeout
// - watchdog timeout nominally 310 ms
// - direct input low off, high on
// - direct input rise wakes from sleep
// - profile select low bulb, high motor
// - any fault drives fault flag low unless asleep
// - per-fault status bits clear on read
// - supervise pwm clock, it sets on-time
// - two bits select sense source or off
// - track-and-hold keeps pre-turn-off value
// - sense off during overcurrent window
// - no sensing in fail-safe or without supply
// - sync low when valid, rises at turn-off
`timescale 1ns/1ps
`default_nettype none
module hsc_ctrl
	import hsc_pkg::*;
#(
	parameter int unsigned SLEEP_DLY = SLEEP_CYC,
	parameter int unsigned WD_TO     = WD_CYC,
	parameter int unsigned CKFAIL_TO = CKFAIL_CYC
) (
	input  wire logic       I_CLK,
	input  wire logic       I_RST_N,
	input  wire logic       I_SPI_SELECT_N,
	input  wire logic       I_SCLK,
	input  wire logic       I_SI,
	input  wire logic       I_WAKE_RESET_N,
	input  wire logic [1:0] I_IN,
	input  wire logic [1:0] I_LOAD_PROFILE_SELECT,
	input  wire logic       I_PWM_CLOCK,
	input  wire hsc_fault_t I_FAULT,
	input  wire logic       I_VDD_OK,
	input  wire logic       I_OC_WINDOW,
	output logic            O_SO,
	output logic            O_SO_OE,
	output logic            O_FAULT_FLAG_N,
	output logic            O_FAULT_FLAG_OE,
	output logic [1:0]      O_CH_ON,
	output logic [1:0]      O_MOTOR_PROFILE,
	output logic [1:0]      O_SENSE_SEL,
	output logic            O_SENSE_OE,
	output logic            O_SENSE_HOLD,
	output logic            O_SYNC_N,
	output logic            O_SYNC_OE,
	output logic            O_FAILSAFE,
	output logic            O_AWAKE
);
	typedef struct packed {
		logic [N_PIN-1:0] s1;
		logic [N_PIN-1:0] s2;
		logic [N_PIN-1:0] s3;
		logic [N_PIN-1:0] f;
		logic [N_PIN-1:0] fp;
		hsc_mode_t        mode;
		logic             wd_act;
		logic             wd_last;
		logic [TMR_W-1:0] wd_cnt;
		logic [TMR_W-1:0] slp_cnt;
		logic [TMR_W-1:0] ck_cnt;
		logic [3:0]       bit_cnt;
		logic             full;
		logic [15:0]      in_sh;
		logic [15:0]      out_sh;
		logic [2:0]       rd_sel;
		logic [2:0]       rd_cur;
		logic [7:0]       global_config_reg;
		logic [2:0]       stat;
		logic [1:0][3:0]  flt;
		logic [1:0][1:0]  dia;
		logic             ck_fail;
		logic [1:0]       ch_on;
		logic [SYC_W-1:0] sync_cnt;
		logic             sync_lo;
		logic             so;
		logic             so_oe;
		logic             ff_oe;
		logic             sns_oe;
		logic             sns_hold;
		logic [1:0]       sns_sel;
		logic [1:0]       motor;
		logic             ff_n;
		logic             sync_n;
		logic             fs;
		logic             awake;
	} hsc_state_t;

	// sync stages start at the idle pin levels, so no false select edge
	localparam hsc_state_t ST_RST = '{
		s1: 9'h001, s2: 9'h001, s3: 9'h001, f: 9'h001, fp: 9'h001,
		mode: M_SLEEP, wd_act: 1'b0, wd_last: 1'b0,
		wd_cnt: '0, slp_cnt: '0, ck_cnt: '0, bit_cnt: '0,
		full: 1'b0, in_sh: '0, out_sh: '0, rd_sel: '0,
		rd_cur: '0, global_config_reg: GCR_RST, stat: '0, flt: '0, dia: '0,
		ck_fail: 1'b0, ch_on: '0, sync_cnt: '0, sync_lo: 1'b0,
		so: 1'b0, so_oe: 1'b0, ff_oe: 1'b0, sns_oe: 1'b0,
		sns_hold: 1'b0, sns_sel: '0, motor: '0, ff_n: 1'b1, sync_n: 1'b1,
		fs: 1'b0, awake: 1'b0};

	hsc_state_t st_reg;
	hsc_state_t st_next;

	// ----------------------------------------------------------
	// edges of the filtered pins
	// ----------------------------------------------------------
	logic        cs_act;
	logic        cs_fall;
	logic        cs_rise;
	logic        sclk_fall;
	logic        sclk_rise;
	logic        rst_pin;
	logic        rst_rise;
	logic [1:0]  in_f;
	logic [1:0]  in_rise;
	logic        pwm_edge;
	logic        accept;
	logic [15:0] rd_val;
	logic [3:0]  waddr;
	logic        any_fault;
	logic        sns_ch;
	logic        sns_on;
	logic        sns_off_edge;

	assign cs_act    = ~st_reg.f[P_CS];
	assign cs_fall   = st_reg.fp[P_CS] & ~st_reg.f[P_CS];
	assign cs_rise   = ~st_reg.fp[P_CS] & st_reg.f[P_CS];
	// select high masks the clock and data pins entirely
	assign sclk_fall = cs_act & st_reg.fp[P_SCLK] & ~st_reg.f[P_SCLK];
	assign sclk_rise = cs_act & ~st_reg.fp[P_SCLK] & st_reg.f[P_SCLK];
	assign rst_pin   = st_reg.f[P_RST];
	assign rst_rise  = rst_pin & ~st_reg.fp[P_RST];
	assign in_f      = st_reg.f[P_IN0+1:P_IN0];
	assign in_rise   = in_f & ~st_reg.fp[P_IN0+1:P_IN0];
	assign pwm_edge  = st_reg.f[P_PWM] ^ st_reg.fp[P_PWM];
	// only whole multiples of 16 bits are taken, so a chain works
	assign accept    = cs_rise & st_reg.full & (st_reg.bit_cnt == '0);
	assign waddr     = st_reg.in_sh[ADDR_HI:ADDR_LO];
	assign any_fault = (|I_FAULT) | st_reg.ck_fail;
	assign sns_ch    = st_reg.sns_sel == SNS_CH1;
	assign sns_on    = st_reg.ch_on[sns_ch];

	// ----------------------------------------------------------
	// readout multiplexer
	// ----------------------------------------------------------
	always_comb begin
		rd_val = '0;
		unique case (st_reg.rd_sel)
			RD_STAT: rd_val = 16'({st_reg.mode, st_reg.wd_act, st_reg.stat});
			RD_FLT0: rd_val = 16'(st_reg.flt[0]);
			RD_FLT1: rd_val = 16'(st_reg.flt[1]);
			RD_DIA0: rd_val = 16'(st_reg.dia[0]);
			RD_DIA1: rd_val = 16'(st_reg.dia[1]);
			RD_GCR:  rd_val = 16'(st_reg.global_config_reg);
			RD_PINS: rd_val = 16'({st_reg.motor, in_f});
			default: rd_val = '0;
		endcase
	end

	// ----------------------------------------------------------
	// next state
	// ----------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		// three stages, a change counts once stages two and three agree
		st_next.s1 = {I_PWM_CLOCK, I_LOAD_PROFILE_SELECT, I_IN,
			I_WAKE_RESET_N, I_SI, I_SCLK, I_SPI_SELECT_N};
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int k = 0; k < N_PIN; k++) begin
			if (st_reg.s2[k] == st_reg.s3[k]) begin
				st_next.f[k] = st_reg.s3[k];
			end
		end
		st_next.fp = st_reg.f;

		// operating mode
		unique case (st_reg.mode)
			M_SLEEP: begin
				if (rst_rise | (|in_rise)) begin
					st_next.mode = M_NORMAL;
				end
			end
			M_NORMAL: begin
				if (st_reg.wd_act && st_reg.wd_cnt >= TMR_W'(WD_TO - 1)) begin
					st_next.mode = M_FAILSAFE;
				end
			end
			M_FAILSAFE: begin
				if (!rst_pin) begin
					st_next.mode = M_NORMAL;
				end
			end
		endcase

		// sleep entry timer, restarted by any high direct input
		st_next.slp_cnt = '0;
		if (st_reg.mode != M_SLEEP && !rst_pin && in_f == 2'h0) begin
			st_next.slp_cnt = st_reg.slp_cnt + 1'b1;
			if (st_reg.slp_cnt >= TMR_W'(SLEEP_DLY - 1)) begin
				st_next.mode = M_SLEEP;
				st_next.slp_cnt = '0;
			end
		end

		// watchdog on the toggle bit of every accepted word
		if (st_reg.wd_act && st_reg.mode == M_NORMAL) begin
			st_next.wd_cnt = st_reg.wd_cnt + 1'b1;
		end
		if (accept && st_reg.in_sh[WD_BIT] != st_reg.wd_last) begin
			st_next.wd_cnt = '0;
			st_next.wd_last = st_reg.in_sh[WD_BIT];
		end
		if (rst_rise) begin
			st_next.wd_act = 1'b1;
			st_next.wd_cnt = '0;
			st_next.wd_last = 1'b0;
		end else if (!rst_pin) begin
			st_next.wd_act = 1'b0;
			st_next.wd_cnt = '0;
		end

		// serial port
		if (cs_fall) begin
			st_next.out_sh = rd_val;
			st_next.so = rd_val[WORD_W-1];
			st_next.so_oe = 1'b1;
			st_next.bit_cnt = '0;
			st_next.full = 1'b0;
			st_next.rd_cur = st_reg.rd_sel;
		end
		if (sclk_fall) begin
			st_next.in_sh = {st_reg.in_sh[WORD_W-2:0], st_reg.f[P_SI]};
			st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
			if (st_reg.bit_cnt == BITS_MAX) begin
				st_next.full = 1'b1;
			end
		end
		if (sclk_rise) begin
			// past the first word the previous input word passes through
			st_next.so = st_reg.full ? st_reg.in_sh[WORD_W-1]
				: st_reg.out_sh[WORD_W-1];
			st_next.out_sh = {st_reg.out_sh[WORD_W-2:0], 1'b0};
		end
		if (cs_rise) begin
			st_next.so_oe = 1'b0;
		end

		if (accept) begin
			if (waddr == A_GCR) begin
				st_next.global_config_reg = st_reg.in_sh[7:0];
			end
			if (waddr == A_RDSEL) begin
				st_next.rd_sel = st_reg.in_sh[2:0];
			end
			unique case (st_reg.rd_cur)
				RD_STAT: st_next.stat = '0;
				RD_FLT0: st_next.flt[0] = '0;
				RD_FLT1: st_next.flt[1] = '0;
				RD_DIA0: st_next.dia[0] = '0;
				RD_DIA1: st_next.dia[1] = '0;
				default: ;
			endcase
		end

		// pwm clock supervision, only while it is selected
		st_next.ck_cnt = '0;
		st_next.ck_fail = 1'b0;
		if (st_reg.global_config_reg[G_EXTCK] && !pwm_edge) begin
			st_next.ck_cnt = st_reg.ck_cnt;
			st_next.ck_fail = st_reg.ck_fail;
			if (st_reg.ck_cnt >= TMR_W'(CKFAIL_TO - 1)) begin
				st_next.ck_fail = 1'b1;
			end else begin
				st_next.ck_cnt = st_reg.ck_cnt + 1'b1;
			end
		end

		// sticky fault bits; a new event wins over the read clear
		st_next.stat = st_next.stat | {st_reg.ck_fail, I_FAULT.ov, I_FAULT.uv};
		for (int c = 0; c < 2; c++) begin
			st_next.flt[c] = st_next.flt[c] | {I_FAULT.oc[c], I_FAULT.ot[c],
				I_FAULT.vpwr_short[c], I_FAULT.severe_sc[c]};
			st_next.dia[c] = st_next.dia[c] | {I_FAULT.open_load_on_state[c], I_FAULT.open_load_off_state[c]};
		end

		// reset pin low holds every register at its reset value
		if (!rst_pin) begin
			st_next.global_config_reg = GCR_RST;
			st_next.rd_sel = '0;
			st_next.stat = '0;
			st_next.flt = '0;
			st_next.dia = '0;
		end

		// channels; fail-safe falls back to the direct inputs
		for (int c = 0; c < 2; c++) begin
			st_next.ch_on[c] = (st_reg.mode != M_SLEEP) & in_f[c];
			if (st_reg.mode == M_NORMAL && st_reg.global_config_reg[G_PWM0+c]
					&& st_reg.global_config_reg[G_EXTCK]) begin
				st_next.ch_on[c] = st_reg.f[P_PWM] & ~st_reg.ck_fail;
			end
		end
		// turn-off seen inside this process, not through a net loop
		sns_off_edge = ~st_next.ch_on[sns_ch] & sns_on;
		st_next.motor = st_reg.f[P_CF0+1:P_CF0];

		// fault flag, open drain
		st_next.ff_oe = (st_reg.mode != M_SLEEP) & any_fault;

		// current and temperature sense
		st_next.sns_sel = {st_reg.global_config_reg[G_SEL_B], st_reg.global_config_reg[G_SEL_A]};
		st_next.sns_oe = (st_reg.sns_sel != SNS_OFF)
			& (st_reg.mode == M_NORMAL) & I_VDD_OK
			& ~I_OC_WINDOW;
		st_next.sns_hold = st_reg.global_config_reg[G_TH_EN] & (st_reg.sns_sel != SNS_OFF)
			& (st_reg.sns_sel != SNS_TEMP) & ~sns_on;

		// sense ready: low after settling, released at turn-off
		if (st_reg.sns_oe && st_reg.sns_sel != SNS_TEMP && sns_on) begin
			if (st_reg.sync_cnt >= SYC_W'(SYNC_CYC - 1)) begin
				st_next.sync_lo = 1'b1;
			end else begin
				st_next.sync_cnt = st_reg.sync_cnt + 1'b1;
			end
		end
		if (sns_off_edge || !st_reg.sns_oe) begin
			st_next.sync_lo = 1'b0;
			st_next.sync_cnt = '0;
		end

		// pin levels kept in flops so outputs carry no decode
		st_next.ff_n = ~st_next.ff_oe;
		st_next.sync_n = ~st_next.sync_lo;
		st_next.fs = st_next.mode == M_FAILSAFE;
		st_next.awake = st_next.mode != M_SLEEP;
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------
	assign O_SO            = st_reg.so;
	assign O_SO_OE         = st_reg.so_oe;
	assign O_FAULT_FLAG_N  = st_reg.ff_n;
	assign O_FAULT_FLAG_OE = st_reg.ff_oe;
	assign O_CH_ON         = st_reg.ch_on;
	assign O_MOTOR_PROFILE = st_reg.motor;
	assign O_SENSE_SEL     = st_reg.sns_sel;
	assign O_SENSE_OE      = st_reg.sns_oe;
	assign O_SENSE_HOLD    = st_reg.sns_hold;
	assign O_SYNC_N        = st_reg.sync_n;
	assign O_SYNC_OE       = st_reg.sync_lo;
	assign O_FAILSAFE      = st_reg.fs;
	assign O_AWAKE         = st_reg.awake;

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	sequence cs_fall_s;
		cs_fall;
	endsequence
	sequence word_in_s;
		accept && waddr == A_GCR;
	endsequence

	chk_so_tristate: assert property (!cs_act && !cs_rise |=> !O_SO_OE)
		else $error("serial output driven with select high");
	chk_so_enable: assert property (cs_fall_s |=> O_SO_OE && O_SO == $past(rd_val[15]))
		else $error("readout not loaded at select fall");
	chk_gcr_latch: assert property (word_in_s and rst_pin |=> st_reg.global_config_reg == $past(st_reg.in_sh[7:0]))
		else $error("config word not latched at select rise");
	chk_si_sample: assert property (sclk_fall |=> st_reg.in_sh[0] == $past(st_reg.f[P_SI]))
		else $error("input bit not sampled at sclk fall");
	chk_reg_hold: assert property ((!rst_pin)[*2] |=> st_reg.global_config_reg == GCR_RST && st_reg.flt == '0)
		else $error("registers not held while reset pin low");
	chk_wd_expire: assert property (st_reg.mode == M_NORMAL && st_reg.wd_act
			&& st_reg.wd_cnt >= TMR_W'(WD_TO - 1) && rst_pin |=> O_FAILSAFE)
		else $error("watchdog expiry did not enter fail-safe");
	chk_ch_direct: assert property (st_reg.mode != M_SLEEP && !st_reg.global_config_reg[G_PWM0]
			|=> O_CH_ON[0] == $past(in_f[0]))
		else $error("channel does not follow direct input");
	chk_in_wake: assert property (st_reg.mode == M_SLEEP && |in_rise |=> O_AWAKE)
		else $error("direct input rise did not wake");
	chk_fault_flag: assert property (O_AWAKE && |I_FAULT |=> O_FAULT_FLAG_OE ##0 !O_FAULT_FLAG_N)
		else $error("fault flag not driven on fault");
	chk_sense_oc: assert property (I_OC_WINDOW |=> !O_SENSE_OE)
		else $error("sense active during overcurrent window");
	chk_sync_off: assert property (sns_off_edge |=> !O_SYNC_OE)
		else $error("sense ready not released at turn-off");
endmodule // hsc_ctrl
`default_nettype wire

// *** hdl/hsc_pkg.sv ***
// constants and types shared by the switch control pin logic
package hsc_pkg;
	// ----------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------
	localparam int CLK_KHZ      = 250_000;
	localparam int T_IN_MS      = 250;
	localparam int SPI_WATCHDOG_TIMEOUT_MS    = 310;
	localparam int T_CKFAIL_US  = 100;
	localparam int T_SYNC_NS    = 2000;
	localparam int SLEEP_CYC    = T_IN_MS * CLK_KHZ;
	localparam int WD_CYC       = SPI_WATCHDOG_TIMEOUT_MS * CLK_KHZ;
	localparam int CKFAIL_CYC   = (T_CKFAIL_US * CLK_KHZ) / 1000;
	localparam int SYNC_CYC     = (T_SYNC_NS * CLK_KHZ) / 1_000_000;
	localparam int TMR_W        = 27;
	localparam int SYC_W        = 10;

	// ----------------------------------------------------------
	// serial word layout
	// ----------------------------------------------------------
	localparam int WORD_W       = 16;
	localparam int WD_BIT       = 15;
	localparam int ADDR_HI      = 12;
	localparam int ADDR_LO      = 9;
	localparam logic [3:0] A_RDSEL = 4'h0;
	localparam logic [3:0] A_GCR   = 4'h1;
	localparam logic [3:0] BITS_MAX = 4'hf;

	// global_config_reg fields
	localparam int G_SEL_A      = 0;
	localparam int G_SEL_B      = 1;
	localparam int G_TH_EN      = 2;
	localparam int G_PWM0       = 3;
	localparam int G_PWM1       = 4;
	localparam int G_EXTCK      = 5;
	localparam logic [7:0] GCR_RST = 8'h00;

	// readable registers
	localparam logic [2:0] RD_STAT  = 3'h0;
	localparam logic [2:0] RD_FLT0  = 3'h1;
	localparam logic [2:0] RD_FLT1  = 3'h2;
	localparam logic [2:0] RD_DIA0  = 3'h3;
	localparam logic [2:0] RD_DIA1  = 3'h4;
	localparam logic [2:0] RD_GCR   = 3'h5;
	localparam logic [2:0] RD_PINS  = 3'h6;

	// sense select codes
	localparam logic [1:0] SNS_OFF  = 2'h0;
	localparam logic [1:0] SNS_CH1  = 2'h2;
	localparam logic [1:0] SNS_TEMP = 2'h3;

	// synchronised pin positions
	localparam int P_CS   = 0;
	localparam int P_SCLK = 1;
	localparam int P_SI   = 2;
	localparam int P_RST  = 3;
	localparam int P_IN0  = 4;
	localparam int P_CF0  = 6;
	localparam int P_PWM  = 8;
	localparam int N_PIN  = 9;

	typedef enum logic [1:0] {M_SLEEP, M_NORMAL, M_FAILSAFE} hsc_mode_t;

	typedef struct packed {
		logic [1:0] oc;
		logic [1:0] ot;
		logic [1:0] vpwr_short;
		logic [1:0] severe_sc;
		logic [1:0] open_load_on_state;
		logic [1:0] open_load_off_state;
		logic       ov;
		logic       uv;
	} hsc_fault_t;
endpackage

// *** tb/hsc_spi_master.sv ***
// serial master model standing in for the controlling microcontroller
`timescale 1ns/1ps
`default_nettype none
module hsc_spi_master (
	input  wire logic i_clk,
	input  wire logic i_so,
	output logic      o_sel_n,
	output logic      o_sclk,
	output logic      o_si
);
	// 160 ns serial period: 20 system cycles per phase
	localparam int HALF = 20;

	initial begin
		o_sel_n = 1'b1;
		o_sclk  = 1'b0;
		o_si    = 1'b0;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// n bits of w, msb first; r holds what so showed just before each fall
	task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
		r = '0;
		@(posedge i_clk);
		o_sel_n <= 1'b0;
		wait_cyc(HALF);
		for (int i = n - 1; i >= 0; i--) begin
			// si moves with the rise, far from the sampling fall
			o_sclk <= 1'b1;
			o_si   <= w[i];
			wait_cyc(HALF);
			r[i] = i_so;
			o_sclk <= 1'b0;
			wait_cyc(HALF);
		end
		// sclk already low before select moves
		o_sel_n <= 1'b1;
		o_si    <= 1'b0;
		wait_cyc(12);
	endtask
endmodule // hsc_spi_master
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the switch control pin logic
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import hsc_pkg::*;
;
	localparam int SLP = 200;
	localparam int WDT = 4000;
	logic        clk, rst_n, sel_n, sclk, si, wake_n, pwm, vdd_ok, ocw, wd;
	logic [1:0]  in_pin, prof, ch_on, motor, sns_sel;
	hsc_fault_t  flt;
	logic        so, so_oe, ff_n, ff_oe, sync_n, sync_oe, fs, awake, hold, sns_oe;
	logic [31:0] rx;
	logic        so_pin;
	// released output shows the inverse of its last bit; nothing pulls it
	assign so_pin = so_oe ? so : ~so;
	int          n_fail, n_tests;

	hsc_ctrl #(.SLEEP_DLY(SLP), .WD_TO(WDT), .CKFAIL_TO(50)) u_dut (
		.I_CLK(clk), .I_RST_N(rst_n), .I_SPI_SELECT_N(sel_n), .I_SCLK(sclk),
		.I_SI(si), .I_WAKE_RESET_N(wake_n), .I_IN(in_pin),
		.I_LOAD_PROFILE_SELECT(prof), .I_PWM_CLOCK(pwm), .I_FAULT(flt),
		.I_VDD_OK(vdd_ok), .I_OC_WINDOW(ocw), .O_SO(so), .O_SO_OE(so_oe),
		.O_FAULT_FLAG_N(ff_n), .O_FAULT_FLAG_OE(ff_oe), .O_CH_ON(ch_on),
		.O_MOTOR_PROFILE(motor), .O_SENSE_SEL(sns_sel), .O_SENSE_OE(sns_oe),
		.O_SENSE_HOLD(hold), .O_SYNC_N(sync_n), .O_SYNC_OE(sync_oe),
		.O_FAILSAFE(fs), .O_AWAKE(awake)
	);

	hsc_spi_master u_mst (.i_clk(clk), .i_so(so_pin), .o_sel_n(sel_n), .o_sclk(sclk), .o_si(si));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic summarize();
		if (n_fail == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// every word flips the toggle bit so the watchdog stays fed
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wd = ~wd;
		u_mst.xfer({16'h0000, wd, 2'b00, a, 1'b0, d}, 16, rx);
	endtask

	task automatic t_wake();
		chk("so_oe", 16'h0, so_oe);
		chk("awake", 16'h0, awake);
		wake_n <= 1'b1;
		cyc(8);
		chk("awake", 16'h1, awake);
		chk("failsafe", 16'h0, fs);
	endtask

	task automatic t_sense();
		for (int c = 0; c < 4; c++) begin
			wr(A_GCR, 8'(c));
			chk("sns_sel", 16'(c), sns_sel);
			chk("sns_oe", 16'(c != 0), sns_oe);
		end
		ocw <= 1'b1;
		cyc(4);
		chk("sns_oe ocw", 16'h0, sns_oe);
		ocw <= 1'b0;
		vdd_ok <= 1'b0;
		cyc(4);
		chk("sns_oe vdd", 16'h0, sns_oe);
		vdd_ok <= 1'b1;
		wr(A_GCR, 8'h07);
		wr(A_RDSEL, {5'h00, RD_GCR});
		wr(A_RDSEL, {5'h00, RD_GCR});
		chk("gcr read", 16'h0007, rx[15:0]);
		chk("so_oe", 16'h0, so_oe);
	endtask

	task automatic t_daisy();
		wd = ~wd;
		u_mst.xfer({16'ha5c3, wd, 2'b00, A_RDSEL, 1'b0, 8'h00}, 32, rx);
		chk("echo", 16'ha5c3, rx[15:0]);
	endtask

	task automatic t_fault();
		flt.oc <= 2'b01;
		cyc(8);
		chk("ff_oe", 16'h1, ff_oe);
		chk("ff_n", 16'h0, ff_n);
		flt <= '0;
		cyc(8);
		chk("ff_oe", 16'h0, ff_oe);
		wr(A_RDSEL, {5'h00, RD_FLT0});
		wr(A_RDSEL, {5'h00, RD_FLT0});
		chk("oc bit", 16'h1, rx[3]);
		wr(A_RDSEL, {5'h00, RD_FLT0});
		chk("oc cleared", 16'h0, rx[3]);
	endtask

	task automatic t_pins();
		in_pin <= 2'b01;
		prof <= 2'b10;
		cyc(8);
		chk("ch_on", 16'h1, ch_on);
		chk("motor", 16'h2, motor);
		in_pin <= 2'b00;
		cyc(8);
		chk("ch_on", 16'h0, ch_on);
	endtask

	task automatic t_clock();
		wr(A_GCR, 8'h28);
		pwm <= 1'b1;
		cyc(10);
		chk("ch_on pwm", 16'h1, ch_on);
		pwm <= 1'b0;
		cyc(10);
		chk("ch_on pwm", 16'h0, ch_on);
		chk("ff_oe clk", 16'h0, ff_oe);
		cyc(80);
		chk("ff_oe clkfail", 16'h1, ff_oe);
	endtask

	task automatic t_sync();
		wr(A_GCR, 8'h05);
		chk("hold off", 16'h1, hold);
		in_pin <= 2'b01;
		cyc(480);
		chk("sync early", 16'h0, sync_oe);
		chk("hold on", 16'h0, hold);
		cyc(40);
		chk("sync_oe", 16'h1, sync_oe);
		chk("sync_n", 16'h0, sync_n);
		in_pin <= 2'b00;
		cyc(8);
		chk("sync off", 16'h0, sync_oe);
		chk("hold again", 16'h1, hold);
	endtask

	task automatic t_wdog();
		cyc(WDT - 1000);
		chk("failsafe", 16'h0, fs);
		cyc(1500);
		chk("failsafe", 16'h1, fs);
		wake_n <= 1'b0;
		cyc(8);
		chk("failsafe", 16'h0, fs);
		chk("gcr held", 16'h0, sns_sel);
		cyc(SLP - 50);
		chk("awake", 16'h1, awake);
		cyc(100);
		chk("asleep", 16'h0, awake);
		in_pin <= 2'b10;
		cyc(8);
		chk("awake in", 16'h1, awake);
		chk("ch_on", 16'h2, ch_on);
	endtask

	initial begin
		n_fail = 0;
		n_tests = 0;
		wd = 1'b0;
		rst_n = 1'b0;
		wake_n = 1'b0;
		pwm = 1'b0;
		vdd_ok = 1'b1;
		ocw = 1'b0;
		in_pin = 2'b00;
		prof = 2'b11;
		flt = '0;
		cyc(16);
		rst_n <= 1'b1;
		cyc(8);
		t_wake();
		t_sense();
		t_daisy();
		t_fault();
		t_pins();
		t_clock();
		t_sync();
		t_wdog();
		summarize();
	end

	// whole run is near 15000 cycles; allow a wide margin
	initial begin
		#200000;
		n_fail++;
		summarize();
	end
endmodule // tb_top
`default_nettype wire
